// [tb/adcc_analog_model.sv]
// comparator and analog input levels seen by the converter
`timescale 1ns/1ps
module adcc_analog_model (
	// converter side
	input  wire logic [3:0] channel_in,
	input  wire logic [9:0] dac_code_in,
	// comparator
	output logic            compare_out
);
	logic [10:0] level;
	// input 15 sits above the high reference
	assign level = (channel_in == 4'hF) ? 11'h7FF : 11'(channel_in) * 11'h03C + 11'h007;
	assign compare_out = ({1'b0, dac_code_in} <= level);
endmodule // adcc_analog_model

// [tb/adcc_top_tb_top.sv]
// self-checking bench of the converter control block
`timescale 1ns/1ps
module adcc_top_tb_top;
	logic        clock_in, resetn_in, rd, wr, halt, cmp, sample, powered, irq, wreq;
	logic [9:0]  addr, dac;
	logic [31:0] wdata, rdata;
	logic [3:0]  chan;
	int          n_errors, compares;

	adcc_top u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.halt_in(halt), .compare_in(cmp), .channel_out(chan), .dac_code_out(dac),
		.sample_out(sample), .powered_out(powered), .irq_out(irq));
	adcc_analog_model u_model (.channel_in(chan), .dac_code_in(dac), .compare_out(cmp));

	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus access, held until waitrequest is seen low
	task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock_in);
		addr <= {idx, 2'h0};
		rd <= !w;
		wr <= w;
		wdata <= {24'h000000, d};
		do begin
			@(posedge clock_in);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_errors++;
			stop_test();
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		access(1'b0, idx, 8'h00, q);
		chk(q, exp);
	endtask

	task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		access(1'b1, idx, d, q);
	endtask

	task automatic t_reset();
		rchk(8'h70, 32'h0);
		rchk(8'h71, 32'h0);
		rchk(8'h72, 32'h0);
		rchk(8'h7F, 32'h0);
		chk({31'h0, powered}, 32'h0);
	endtask

	task automatic t_convert(input logic [3:0] ch, input logic spd);
		logic [31:0] q;
		logic [9:0]  ev;
		int          n;
		ev = (ch == 4'hF) ? 10'h3FF : 10'(ch) * 10'h03C + 10'h007;
		wreg(8'h70, {2'b00, spd, 1'b1, 1'b0, ch});
		n = 0;
		do begin
			access(1'b0, 8'h70, 8'h00, q);
			n++;
		end while (q[7] !== 1'b1 && n < 100);
		chk(q, {24'h0, 2'b10 | spd, 1'b1, 1'b0, ch});
		rchk(8'h72, {30'h0, ev[1:0]});
		rchk(8'h71, {24'h0, ev[9:2]});
		rchk(8'h70, {24'h0, 1'b0, spd, 1'b1, 1'b0, ch});
		chk({28'h0, chan}, {28'h0, ch});
	endtask

	task automatic t_halt();
		halt <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk({31'h0, powered}, 32'h0);
		halt <= 1'b0;
	endtask

	task automatic t_irq();
		int n;
		wreg(8'h74, 8'h01);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge clock_in);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
		rchk(8'h73, 32'h1);
		wreg(8'h74, 8'h00);
		repeat (2) @(posedge clock_in);
		chk({31'h0, irq}, 32'h0);
	endtask

	initial begin
		n_errors = 0;
		compares = 0;
		{rd, wr, halt} = 3'b000;
		addr = 10'h000;
		wdata = 32'h0;
		resetn_in = 1'b0;
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		t_reset();
		t_convert(4'h5, 1'b1);
		t_convert(4'hF, 1'b0);
		t_convert(4'h0, 1'b1);
		t_halt();
		t_convert(4'hE, 1'b0);
		t_irq();
		stop_test();
	end
endmodule // adcc_top_tb_top

// [verilog/adcc_defs.svh]
// register indexes, field positions, reset values and timing counts of the converter block
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_IDX_CSR      8'h70
`define ADCC_IDX_UPPER    8'h71
`define ADCC_IDX_LOWER    8'h72
`define ADCC_IDX_STATUS   8'h73
`define ADCC_IDX_MASK     8'h74
`define ADCC_BIT_DONE     7
`define ADCC_BIT_SPEED    6
`define ADCC_BIT_ON       5
`define ADCC_BIT_RSVD     4
`define ADCC_SEL_HI       3
`define ADCC_SEL_LO       0
`define ADCC_RST_CSR      8'h00
`define ADCC_RST_RESULT   10'h000
`define ADCC_RST_MASK     1'b0
`define ADCC_DIV_FAST     2'h1
`define ADCC_DIV_SLOW     2'h3
`define ADCC_RES_MSB      10'h200
`endif

// [verilog/adcc_pkg.sv]
// types shared by the converter control block
package adcc_pkg;
	typedef enum logic [1:0] {
		ADCC_IDLE,
		ADCC_SAMPLE,
		ADCC_CONVERT
	} adcc_phase_type;

	typedef struct packed {
		logic           waitreq;
		logic [31:0]    rdata;
		logic           done;
		logic           speed;
		logic           on;
		logic [3:0]     sel;
		logic [1:0]     div;
		adcc_phase_type ph;
		logic [3:0]     bit_idx;
		logic [9:0]     trial;
		logic [9:0]     result;
		logic           samp;
		logic           powered;
		logic           irq_stat;
		logic           irq_mask;
		logic           irq;
	} adcc_state_type;
endpackage

// [verilog/adcc_top.sv]
// converter control, status and result registers with a successive-approximation sequencer
// Behaviour
// [RQ1] Bit 7 of the control/status register is set when a conversion completes.
// [RQ2] Reading the upper result or writing the control/status register clears that flag.
// [RQ3] Bit 6 picks a conversion clock of core clock over 4 (0) or over 2 (1).
// [RQ4] Bit 5 switches the converter on and starts it, or off and stops it.
// [RQ5] Software writes 0 to reserved bit 4.
// [RQ6] Bits 3 to 0 pick which of 16 analog inputs is converted.
// [RQ7] The upper result register reads result bits 9 to 2.
// [RQ8] The lower result register reads result bits 1 and 0, zero above.
// [RQ9] Wait mode changes nothing in the converter.
// [RQ10] Halt disables the converter and software waits a settle time after wake-up.
// [RQ11] The converter raises no interrupt of its own; software polls the flag. Here irq_out is driven by irq_stat and irq_mask.
// [RQ12] While on, conversions follow each other without a break.
// [RQ13] Changing the input selection aborts, clears the flag and restarts.
// [RQ14] An input above the high reference yields FFh upper and 03h lower.
// [RQ15] Software reads lower then upper result before the next conversion ends.
// [RQ16] Both result registers change in the cycle the flag is set.
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_top (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        resetn_in,
	// register bus
	input  wire logic [9:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// power mode
	input  wire logic        halt_in,
	// analog multiplexer and comparator
	input  wire logic        compare_in,
	output logic      [3:0]  channel_out,
	output logic      [9:0]  dac_code_out,
	output logic             sample_out,
	output logic             powered_out,
	// interrupt
	output logic             irq_out
);
	import adcc_pkg::*;

	adcc_state_type r;
	adcc_state_type n;
	logic           acc;
	logic           fin_ev;
	logic           tick;
	logic [7:0]     idx;
	logic [7:0]     csr_view;

	function automatic logic [9:0] bit_mask(input logic [3:0] i);
		bit_mask = 10'h001 << i;
	endfunction

	assign idx      = avs_address_in[9:2];
	assign acc      = (avs_read_in | avs_write_in) & r.waitreq;
	assign csr_view = {r.done, r.speed, r.on, 1'b0, r.sel};

	always_comb begin
		n        = r;
		fin_ev   = 1'b0;
		tick     = 1'b0;
		n.waitreq = 1'b1;
		// bus access: answer one cycle after the request is seen
		if (acc) begin
			n.waitreq = 1'b0;
			n.rdata   = 32'h0000_0000;
			if (avs_read_in) begin
				case (idx)
					`ADCC_IDX_CSR: n.rdata[7:0] = csr_view;
					`ADCC_IDX_UPPER: begin
						n.rdata[7:0] = r.result[9:2]; // RQ7
						n.done       = 1'b0; // RQ2
					end
					`ADCC_IDX_LOWER: n.rdata[1:0] = r.result[1:0]; // RQ8
					`ADCC_IDX_STATUS: begin
						n.rdata[0]  = r.irq_stat;
						n.irq_stat  = 1'b0;
					end
					`ADCC_IDX_MASK: n.rdata[0] = r.irq_mask;
					default: n.rdata = 32'h0000_0000;
				endcase
			end else if (avs_byteenable_in[0]) begin
				case (idx)
					`ADCC_IDX_CSR: begin
						n.done  = 1'b0; // RQ2
						n.speed = avs_writedata_in[`ADCC_BIT_SPEED]; // RQ3
						n.on    = avs_writedata_in[`ADCC_BIT_ON]; // RQ4
						n.sel   = avs_writedata_in[`ADCC_SEL_HI:`ADCC_SEL_LO]; // RQ6
					end
					`ADCC_IDX_MASK: n.irq_mask = avs_writedata_in[0];
					default: n.irq_mask = n.irq_mask;
				endcase
			end
		end
		// halt gates the converter off; wait mode is not a term here
		if (!(n.on && !halt_in)) begin // RQ4 RQ9 RQ10
			n.ph      = ADCC_IDLE;
			n.samp    = 1'b0;
			n.powered = 1'b0;
			n.div     = 2'h0;
		end else if (n.sel != r.sel || r.ph == ADCC_IDLE) begin
			// fresh start or new input: restart from sampling
			n.ph      = ADCC_SAMPLE; // RQ13
			n.samp    = 1'b1;
			n.powered = 1'b1;
			n.div     = 2'h0;
			if (n.sel != r.sel) begin
				n.done = 1'b0; // RQ13
			end
		end else begin
			tick  = (r.div == (r.speed ? `ADCC_DIV_FAST : `ADCC_DIV_SLOW)); // RQ3
			n.div = tick ? 2'h0 : r.div + 2'h1;
			if (tick) begin
				case (r.ph)
					ADCC_SAMPLE: begin
						n.samp    = 1'b0;
						n.trial   = `ADCC_RES_MSB;
						n.bit_idx = 4'h9;
						n.ph      = ADCC_CONVERT;
					end
					ADCC_CONVERT: begin
						// comparator low: trial code too high, drop this bit
						if (!compare_in) begin
							n.trial = r.trial & ~bit_mask(r.bit_idx);
						end
						if (r.bit_idx != 4'h0) begin
							n.trial   = n.trial | bit_mask(r.bit_idx - 4'h1);
							n.bit_idx = r.bit_idx - 4'h1;
						end else begin
							// all ones when input is over the reference
							n.result   = n.trial; // RQ14 RQ16
							n.done     = 1'b1; // RQ1
							n.irq_stat = 1'b1;
							fin_ev     = 1'b1;
							n.ph       = ADCC_SAMPLE; // RQ12
							n.samp     = 1'b1;
						end
					end
					default: n.ph = ADCC_IDLE;
				endcase
			end
		end
		n.irq = n.irq_stat & n.irq_mask;
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			r          <= '0;
			r.waitreq  <= 1'b1;
			{r.done, r.speed, r.on} <= 3'h0;
			r.sel      <= 4'(`ADCC_RST_CSR);
			r.result   <= `ADCC_RST_RESULT;
			r.irq_mask <= `ADCC_RST_MASK;
			r.ph       <= ADCC_IDLE;
		end else begin
			r <= n;
		end
	end

	assign avs_readdata_out    = r.rdata;
	assign avs_waitrequest_out = r.waitreq;
	assign channel_out         = r.sel; // RQ6
	assign dac_code_out        = r.trial;
	assign sample_out          = r.samp;
	assign powered_out         = r.powered;
	assign irq_out             = r.irq; // RQ11

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);

	property p_res_done;
		$changed(r.result) |-> r.done && $past(r.ph) == ADCC_CONVERT;
	endproperty
	a_res_done: assert property (p_res_done) else $error("result moved without done"); // RQ16

	property p_upper_clr;
		acc && avs_read_in && idx == `ADCC_IDX_UPPER && !fin_ev |=> !r.done;
	endproperty
	a_upper_clr: assert property (p_upper_clr) else $error("upper read left done set"); // RQ2

	property p_div;
		tick |-> r.div == (r.speed ? 2'h1 : 2'h3);
	endproperty
	a_div: assert property (p_div) else $error("conversion clock divide wrong"); // RQ3

	property p_off;
		!n.on |=> !powered_out && !sample_out;
	endproperty
	a_off: assert property (p_off) else $error("converter runs while off"); // RQ4

	property p_chan;
		acc && avs_write_in && idx == `ADCC_IDX_CSR && avs_byteenable_in[0] && !halt_in
			&& avs_writedata_in[5] && avs_writedata_in[3:0] != r.sel
			|=> sample_out && !r.done && !avs_waitrequest_out;
	endproperty
	a_chan: assert property (p_chan) else $error("input change did not restart"); // RQ13

	property p_lower;
		acc && avs_read_in && idx == `ADCC_IDX_LOWER
			|=> avs_readdata_out[31:2] == 30'h0 && avs_readdata_out[1:0] == $past(r.result[1:0]);
	endproperty
	a_lower: assert property (p_lower) else $error("lower result read wrong"); // RQ8

	property p_upper;
		acc && avs_read_in && idx == `ADCC_IDX_UPPER
			|=> avs_readdata_out[7:0] == $past(r.result[9:2]);
	endproperty
	a_upper: assert property (p_upper) else $error("upper result read wrong"); // RQ7

	property p_halt;
		halt_in |=> !powered_out;
	endproperty
	a_halt: assert property (p_halt) else $error("converter powered in halt"); // RQ10

	property p_cont;
		fin_ev && r.on && !halt_in && !acc |=> sample_out && r.done;
	endproperty
	a_cont: assert property (p_cont) else $error("no restart after completion"); // RQ12

	c_done: cover property (fin_ev);
	c_over: cover property (fin_ev && n.result == 10'h3FF);
	c_halt: cover property (r.powered ##1 halt_in ##1 !r.powered);

	// done flag and result registers
	property p_done_set;
		fin_ev |=> r.done;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set at completion"); // RQ1

	property p_csr_clr;
		acc && avs_write_in && idx == `ADCC_IDX_CSR && avs_byteenable_in[0] && !fin_ev
			|=> !r.done;
	endproperty
	a_csr_clr: assert property (p_csr_clr) else $error("control write left done set"); // RQ2

	property p_res_keep;
		!fin_ev |=> $stable(r.result);
	endproperty
	a_res_keep: assert property (p_res_keep) else $error("result moved between completions"); // RQ16

	// control fields follow software writes
	property p_speed_wr;
		acc && avs_write_in && idx == `ADCC_IDX_CSR && avs_byteenable_in[0]
			|=> r.speed == $past(avs_writedata_in[`ADCC_BIT_SPEED]);
	endproperty
	a_speed_wr: assert property (p_speed_wr) else $error("speed bit not written"); // RQ3

	property p_on_wr;
		acc && avs_write_in && idx == `ADCC_IDX_CSR && avs_byteenable_in[0]
			|=> r.on == $past(avs_writedata_in[`ADCC_BIT_ON]);
	endproperty
	a_on_wr: assert property (p_on_wr) else $error("on bit not written"); // RQ4

	property p_sel_wr;
		acc && avs_write_in && idx == `ADCC_IDX_CSR && avs_byteenable_in[0]
			|=> channel_out == $past(avs_writedata_in[3:0]);
	endproperty
	a_sel_wr: assert property (p_sel_wr) else $error("input select not written"); // RQ6

	property p_sel_stable;
		!(acc && avs_write_in) |=> $stable(channel_out);
	endproperty
	a_sel_stable: assert property (p_sel_stable) else $error("input select moved alone"); // RQ6

	property p_rsvd;
		acc && avs_read_in && idx == `ADCC_IDX_CSR |=> avs_readdata_out[`ADCC_BIT_RSVD] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one"); // RQ5

	// bus answer lasts one cycle
	property p_one_wait;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("waitrequest low too long");

	// sequencer holds its code between conversion clock ticks
	property p_dac_hold;
		!tick |=> $stable(dac_code_out);
	endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("trial code moved off tick"); // RQ12

	property p_halt_samp;
		halt_in |=> !sample_out;
	endproperty
	a_halt_samp: assert property (p_halt_samp) else $error("sampling during halt"); // RQ10

	property p_irq;
		irq_out |-> r.irq_stat && r.irq_mask;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without masked status"); // RQ11

	// channel change and back-to-back conversions
	c_chan: cover property (acc && avs_write_in && idx == `ADCC_IDX_CSR && n.sel != r.sel);
	c_back: cover property (fin_ev ##[1:60] fin_ev);
endmodule // adcc_top
